// ===== common/rtc_flags_pkg.sv
package rtc_flags_pkg;
  localparam logic [6:0] IDX_RATE_A     = 7'h0a;
  localparam logic [6:0] IDX_CONTROL_B  = 7'h0b;
  localparam logic [6:0] IDX_FLAGS_C    = 7'h0c;
  localparam logic [6:0] IDX_STATUS_D   = 7'h0d;
  localparam logic [6:0] IDX_SEC        = 7'h00;
  localparam logic [6:0] IDX_ALM_SEC    = 7'h01;
  localparam logic [6:0] IDX_MIN        = 7'h02;
  localparam logic [6:0] IDX_ALM_MIN    = 7'h03;
  localparam logic [6:0] IDX_HOUR       = 7'h04;
  localparam logic [6:0] IDX_ALM_HOUR   = 7'h05;
  localparam int         POS_MASTER     = 7;
  localparam int         POS_PERIODIC   = 6;
  localparam int         POS_ALARM      = 5;
  localparam int         POS_UPDATE     = 4;
  localparam logic [7:0] WILDCARD_BASE  = 8'hc0;
  localparam logic [7:0] STATUS_D_VALUE = 8'h80;
  localparam logic [3:0] RATE_OFF       = 4'h0;
  localparam logic [7:0] RESET_ZERO     = 8'h00;
  localparam int         TICK_HZ        = 32768;
  localparam int         CLK_HZ         = 200000000;
  localparam int         CYCLES_PER_TICK = CLK_HZ / TICK_HZ;
endpackage

// ===== design/rtc_alarm_match.sv
`timescale 1ns/100ps
module rtc_alarm_match
  import rtc_flags_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       second_tick,
  input  wire logic [7:0] cur_sec,
  input  wire logic [7:0] cur_min,
  input  wire logic [7:0] cur_hour,
  input  wire logic [7:0] alm_sec,
  input  wire logic [7:0] alm_min,
  input  wire logic [7:0] alm_hour,
  output logic            alarm_event
);
  typedef struct packed {
    logic hit;
  } alm_st_t;
  alm_st_t st_r;
  alm_st_t st_nxt;
  logic [2:0] field_ok;
  logic [23:0] cur_all;
  logic [23:0] alm_all;

  assign cur_all = {cur_hour, cur_min, cur_sec};
  assign alm_all = {alm_hour, alm_min, alm_sec};

  for (genvar i = 0; i < 3; i++) begin : g_field
    assign field_ok[i] = (alm_all[i*8 +: 8] >= WILDCARD_BASE) ||
                         (alm_all[i*8 +: 8] == cur_all[i*8 +: 8]);
  end

  always_comb begin
    st_nxt     = st_r;
    // Compared once per second so a match raises one event only.
    st_nxt.hit = second_tick && (&field_ok);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign alarm_event = st_r.hit;
endmodule

// ===== design/rtc_interrupt_flags.sv
`timescale 1ns/100ps
module rtc_interrupt_flags
  import rtc_flags_pkg::*;
#(
  parameter int TICKS_PER_SECOND = TICK_HZ,
  parameter int DIV              = CYCLES_PER_TICK
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       rtc_subsys_rst,
  input  wire logic       port_decode_en,
  input  wire logic       idx_wr,
  input  wire logic       data_wr,
  input  wire logic       data_rd,
  input  wire logic [7:0] wr_data,
  output logic [7:0]      rd_data,
  output logic            host_interrupt_line_eight
);
  typedef struct packed {
    logic [6:0] index;
    logic [3:0] rate;
    logic       set_inhibit;
    logic       periodic_event_enable;
    logic       alarm_event_enable;
    logic       update_done_enable;
    logic       master_request_flag;
    logic       pf;
    logic       af;
    logic       uf;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] alm_sec;
    logic [7:0] alm_min;
    logic [7:0] alm_hour;
    logic [15:0] sub;
    logic       upd_done;
    logic [7:0] rd;
  } flag_st_t;

  flag_st_t st_r;
  flag_st_t st_nxt;
  logic     tick;
  logic     periodic_event;
  logic     alarm_event;
  logic     upd_event;
  logic     sec_tick;
  logic     rd_flags;
  logic [7:0] flags_view;

  rtc_tick_gen #(
    .DIV (DIV)
  ) u_tick (
    .mclk                 (mclk),
    .sys_rst              (sys_rst),
    .periodic_rate_select (st_r.rate),
    .tick                 (tick),
    .periodic_event       (periodic_event)
  );

  rtc_alarm_match u_alarm (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .second_tick (st_r.upd_done),
    .cur_sec     (st_r.sec),
    .cur_min     (st_r.min),
    .cur_hour    (st_r.hour),
    .alm_sec     (st_r.alm_sec),
    .alm_min     (st_r.alm_min),
    .alm_hour    (st_r.alm_hour),
    .alarm_event (alarm_event)
  );

  assign sec_tick  = tick && (st_r.sub == 16'(TICKS_PER_SECOND - 1));
  assign upd_event = st_r.upd_done;
  assign rd_flags  = port_decode_en && data_rd && (st_r.index == IDX_FLAGS_C);
  // Low nibble is hard zero.
  assign flags_view = {st_r.master_request_flag, st_r.pf, st_r.af, st_r.uf, 4'h0};

  always_comb begin
    st_nxt          = st_r;
    st_nxt.upd_done = 1'b0;
    if (tick) begin
      st_nxt.sub = (sec_tick) ? 16'h0000 : st_r.sub + 16'h0001;
    end
    // Binary time keeping; one update cycle per second when not inhibited.
    if (sec_tick && !st_r.set_inhibit) begin
      st_nxt.upd_done = 1'b1;
      if (st_r.sec == 8'd59) begin
        st_nxt.sec = 8'h00;
        if (st_r.min == 8'd59) begin
          st_nxt.min  = 8'h00;
          st_nxt.hour = (st_r.hour == 8'd23) ? 8'h00 : st_r.hour + 8'h01;
        end else begin
          st_nxt.min = st_r.min + 8'h01;
        end
      end else begin
        st_nxt.sec = st_r.sec + 8'h01;
      end
    end
    if (port_decode_en && idx_wr) begin
      st_nxt.index = wr_data[6:0];
    end
    if (port_decode_en && data_rd) begin
      if (st_r.index == IDX_FLAGS_C) begin
        st_nxt.rd = flags_view;
      end else if (st_r.index == IDX_STATUS_D) begin
        st_nxt.rd = STATUS_D_VALUE;
      end else if (st_r.index == IDX_RATE_A) begin
        st_nxt.rd = {4'h0, st_r.rate};
      end else if (st_r.index == IDX_CONTROL_B) begin
        st_nxt.rd = {st_r.set_inhibit, st_r.periodic_event_enable, st_r.alarm_event_enable, st_r.update_done_enable, 4'h0};
      end else if (st_r.index == IDX_SEC) begin
        st_nxt.rd = st_r.sec;
      end else if (st_r.index == IDX_ALM_SEC) begin
        st_nxt.rd = st_r.alm_sec;
      end else if (st_r.index == IDX_MIN) begin
        st_nxt.rd = st_r.min;
      end else if (st_r.index == IDX_ALM_MIN) begin
        st_nxt.rd = st_r.alm_min;
      end else if (st_r.index == IDX_HOUR) begin
        st_nxt.rd = st_r.hour;
      end else if (st_r.index == IDX_ALM_HOUR) begin
        st_nxt.rd = st_r.alm_hour;
      end else begin
        st_nxt.rd = RESET_ZERO;
      end
    end
    // Flags clear on read; the event terms below are applied afterwards.
    if (rd_flags) begin
      st_nxt.master_request_flag = 1'b0;
      st_nxt.pf   = 1'b0;
      st_nxt.af   = 1'b0;
      st_nxt.uf   = 1'b0;
    end
    if (port_decode_en && data_wr) begin
      if (st_r.index == IDX_RATE_A) begin
        st_nxt.rate = wr_data[3:0];
      end else if (st_r.index == IDX_CONTROL_B) begin
        st_nxt.set_inhibit = wr_data[7];
        st_nxt.periodic_event_enable         = wr_data[POS_PERIODIC];
        st_nxt.alarm_event_enable         = wr_data[POS_ALARM];
        st_nxt.update_done_enable         = wr_data[POS_UPDATE] && !wr_data[7];
        if ((wr_data[POS_PERIODIC] && !st_r.periodic_event_enable && st_r.pf) ||
            (wr_data[POS_ALARM] && !st_r.alarm_event_enable && st_r.af) ||
            (wr_data[POS_UPDATE] && !wr_data[7] && !st_r.update_done_enable &&
             st_r.uf)) begin
          st_nxt.master_request_flag = 1'b1;
        end
      end else if (st_r.index == IDX_SEC) begin
        st_nxt.sec = wr_data;
      end else if (st_r.index == IDX_ALM_SEC) begin
        st_nxt.alm_sec = wr_data;
      end else if (st_r.index == IDX_MIN) begin
        st_nxt.min = wr_data;
      end else if (st_r.index == IDX_ALM_MIN) begin
        st_nxt.alm_min = wr_data;
      end else if (st_r.index == IDX_HOUR) begin
        st_nxt.hour = wr_data;
      end else if (st_r.index == IDX_ALM_HOUR) begin
        st_nxt.alm_hour = wr_data;
      end
    end
    // Events win over a same-cycle clearing read so none is lost.
    if (periodic_event) begin
      st_nxt.pf = 1'b1;
      if (st_r.periodic_event_enable && (!st_r.pf || rd_flags)) begin
        st_nxt.master_request_flag = 1'b1;
      end
    end
    if (alarm_event) begin
      st_nxt.af = 1'b1;
      if (st_r.alarm_event_enable && (!st_r.af || rd_flags)) begin
        st_nxt.master_request_flag = 1'b1;
      end
    end
    if (upd_event) begin
      st_nxt.uf = 1'b1;
      if (st_r.update_done_enable && (!st_r.uf || rd_flags)) begin
        st_nxt.master_request_flag = 1'b1;
      end
    end
    if (rtc_subsys_rst) begin
      st_nxt.master_request_flag = 1'b0;
      st_nxt.pf   = 1'b0;
      st_nxt.af   = 1'b0;
      st_nxt.uf   = 1'b0;
      st_nxt.periodic_event_enable  = 1'b0;
      st_nxt.alarm_event_enable  = 1'b0;
      st_nxt.update_done_enable  = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd;
  // The line follows the flag alone, independent of port decode.
  assign host_interrupt_line_eight = st_r.master_request_flag;
endmodule

// ===== design/rtc_tick_gen.sv
`timescale 1ns/100ps
module rtc_tick_gen
  import rtc_flags_pkg::*;
#(
  parameter int DIV = CYCLES_PER_TICK
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] periodic_rate_select,
  output logic            tick,
  output logic            periodic_event
);
  typedef struct packed {
    logic [15:0] pre;
    logic [14:0] chain;
    logic        tick;
    logic        per;
  } tick_st_t;
  tick_st_t st_r;
  tick_st_t st_nxt;
  logic [3:0] tap;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.per  = 1'b0;
    // Codes 1 and 2 alias onto the 3.906 and 7.812 ms rates.
    // Chain bit k falls once every 2^(k+1) ticks, so code 3 taps bit 1.
    if (periodic_rate_select == 4'h1) begin
      tap = 4'h6;
    end else if (periodic_rate_select == 4'h2) begin
      tap = 4'h7;
    end else begin
      tap = 4'(periodic_rate_select - 4'h2);
    end
    if (st_r.pre == 16'(DIV - 1)) begin
      st_nxt.pre   = 16'h0000;
      st_nxt.tick  = 1'b1;
      st_nxt.chain = st_r.chain + 15'h0001;
      if (periodic_rate_select != RATE_OFF) begin
        if (st_nxt.chain[tap] != st_r.chain[tap] && !st_nxt.chain[tap]) begin
          st_nxt.per = 1'b1;
        end
      end
    end else begin
      st_nxt.pre = st_r.pre + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick           = st_r.tick;
  assign periodic_event = st_r.per;
endmodule

// ===== test/rtc_flags_checker.sv
`timescale 1ns/100ps
module rtc_flags_checker
  import rtc_flags_pkg::*;
#(
  parameter int TICKS_PER_SECOND = TICK_HZ,
  parameter int DIV              = CYCLES_PER_TICK
) (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       rtc_subsys_rst,
  input wire logic       port_decode_en,
  input wire logic       idx_wr,
  input wire logic       data_wr,
  input wire logic       data_rd,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic       host_interrupt_line_eight
);
  logic [6:0] idx_r;
  logic [2:0] en_r;
  logic       irq;
  logic       sel;
  logic       clr_rd;
  assign irq    = host_interrupt_line_eight;
  assign sel    = data_rd && port_decode_en;
  assign clr_rd = sel && idx_r == IDX_FLAGS_C;
  // A SET write drops the update enable, so the mirror drops it too.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      idx_r <= 7'h00;
    end else if (idx_wr && port_decode_en) begin
      idx_r <= wr_data[6:0];
    end
    if (sys_rst || rtc_subsys_rst) begin
      en_r <= 3'h0;
    end else if (data_wr && port_decode_en && idx_r == IDX_CONTROL_B) begin
      en_r <= wr_data[6:4] & {2'h3, !wr_data[7]};
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_SUBSYS_CLR: assert property (rtc_subsys_rst |=> !irq)
    else $error("line high after subsystem reset");
  AST_RD_CAPTURE: assert property (clr_rd |=> rd_data[7] == $past(irq))
    else $error("read lost the master flag");
  AST_LOW_ZERO: assert property (clr_rd |=> rd_data[3:0] == 4'h0)
    else $error("low flag bits not zero");
  AST_IRQ_HOLD: assert property (irq && !clr_rd && !rtc_subsys_rst |=> irq)
    else $error("line dropped without a clear");
  AST_DECODE_OFF: assert property (irq && !port_decode_en &&
    !rtc_subsys_rst |=> irq) else $error("line dropped with decode off");
  AST_RISE_EN: assert property ($rose(irq) |-> en_r || $past(en_r))
    else $error("line rose with no enable");
  AST_STATUS_D: assert property (sel && idx_r == IDX_STATUS_D |=>
    rd_data == STATUS_D_VALUE) else $error("status byte wrong");
  AST_ENABLES: assert property (sel && idx_r == IDX_CONTROL_B |=>
    rd_data[6:4] == $past(en_r)) else $error("enable bits wrong");
  cover property ($rose(irq));
  cover property (clr_rd && irq);
  cover property (!port_decode_en && irq);
endmodule
bind rtc_interrupt_flags rtc_flags_checker #(
  .TICKS_PER_SECOND(TICKS_PER_SECOND), .DIV(DIV)
) chk_inst (
  .mclk(mclk), .sys_rst(sys_rst), .rtc_subsys_rst(rtc_subsys_rst),
  .port_decode_en(port_decode_en), .idx_wr(idx_wr), .data_wr(data_wr),
  .data_rd(data_rd), .wr_data(wr_data), .rd_data(rd_data),
  .host_interrupt_line_eight(host_interrupt_line_eight)
);

// ===== test/rtc_host_model.sv
`timescale 1ns/100ps
module rtc_host_model
  import rtc_flags_pkg::*;
(
  input  wire logic  mclk,
  output logic       port_decode_en,
  output logic       idx_wr,
  output logic       data_wr,
  output logic       data_rd,
  output logic [7:0] wr_data
);
  initial begin
    port_decode_en = 1'b1;
    {idx_wr, data_wr, data_rd} = 3'h0;
    wr_data = 8'h5a;
  end
  // Unused data bytes are inverted so a stale byte never passes for good.
  task automatic go(input logic [6:0] i, input logic [7:0] d, input logic r);
    @(posedge mclk) #1;
    idx_wr = 1'b1;
    wr_data = {1'b0, i};
    @(posedge mclk) #1;
    {idx_wr, data_wr, data_rd} = {1'b0, !r, r};
    wr_data = r ? ~wr_data : d;
    @(posedge mclk) #1;
    {data_wr, data_rd} = 2'h0;
    wr_data = ~wr_data;
  endtask
  task automatic decode(input logic on);
    if (!on) go(IDX_CONTROL_B, 8'h80, 1'b0);
    @(posedge mclk) #1;
    port_decode_en = on;
  endtask
endmodule

// ===== test/tb_rtc_interrupt_flags.sv
`timescale 1ns/100ps
module tb_rtc_interrupt_flags;
  import rtc_flags_pkg::*;
  logic       mclk;
  logic       sys_rst;
  logic       rtc_subsys_rst;
  logic       port_decode_en;
  logic       idx_wr;
  logic       data_wr;
  logic       data_rd;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       host_interrupt_line_eight;
  logic [7:0] irqb;
  int         error_cnt;
  int         num_checks;
  int         n;
  int         s;
  int         hr;
  int         m_flg;
  int         m_en;
  int         m_set;
  int         m_irq;
  logic [7:0] exp_q[$];
  assign irqb = {7'h00, host_interrupt_line_eight};
  // A second is 32 cycles here, so alarms fit in a short run.
  rtc_interrupt_flags #(.TICKS_PER_SECOND(16), .DIV(2))
    rtc_interrupt_flags_inst (.*);
  rtc_host_model rtc_host_model_inst (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("Error %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Rule-level model; scenarios post the events they are sure have occurred.
  task automatic m_evt(input int pos);
    if (!m_flg[pos] && m_en[pos]) m_irq = 1;
    m_flg[pos] = 1'b1;
  endtask
  // A SET write drops the update enable, and a new enable over a set flag
  // raises the master flag at once.
  task automatic m_wr(input logic [6:0] i, input logic [7:0] d);
    int en;
    en = d & (d[7] ? 8'h60 : 8'h70);
    if (i == IDX_CONTROL_B) begin
      if ((en & ~m_en & m_flg) != 0) m_irq = 1;
      m_en = en;
      m_set = d[7];
    end
  endtask
  task automatic rd(input logic [6:0] i);
    exp_q.delete();
    if (i == IDX_FLAGS_C) begin
      exp_q.push_back(8'((m_irq << 7) | m_flg));
      if (port_decode_en) begin
        m_irq = 0;
        m_flg = 0;
      end
    end else if (i == IDX_CONTROL_B) begin
      exp_q.push_back(8'((m_set << 7) | m_en));
    end else begin
      exp_q.push_back(STATUS_D_VALUE);
    end
    rtc_host_model_inst.go(i, 8'h00, 1'b1);
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    m_wr(i, d);
    rtc_host_model_inst.go(i, d, 1'b0);
  endtask
  task automatic wait_irq();
    for (n = 0; n < 80 && irqb !== 8'h01; n++) @(posedge mclk) #1;
    if (irqb !== 8'h01) begin
      chk(irqb, 8'h01);
      complete_run();
    end
  endtask
  initial begin
    error_cnt = 0;
    num_checks = 0;
    m_flg = 0;
    m_en = 0;
    m_set = 0;
    m_irq = 0;
    sys_rst = 1'b1;
    rtc_subsys_rst = 1'b0;
    s = $urandom(22);
    repeat (8) @(posedge mclk);
    #1 sys_rst = 1'b0;
    wr(IDX_CONTROL_B, 8'h80);
    rd(IDX_FLAGS_C);
    repeat (40) @(posedge mclk);
    rd(IDX_FLAGS_C);
    chk(rd_data, exp_q.pop_front());
    rd(IDX_STATUS_D);
    chk(rd_data, exp_q.pop_front());
    wr(IDX_RATE_A, 8'h03);
    repeat (20) @(posedge mclk) #1;
    m_evt(POS_PERIODIC);
    chk(irqb, 8'(m_irq));
    wr(IDX_CONTROL_B, 8'hc0);
    @(posedge mclk) #1;
    chk(irqb, 8'(m_irq));
    wr(IDX_RATE_A, 8'h00);
    rd(IDX_FLAGS_C);
    chk(rd_data, exp_q.pop_front());
    chk(irqb, 8'(m_irq));
    rd(IDX_FLAGS_C);
    chk(rd_data, exp_q.pop_front());
    wr(IDX_CONTROL_B, 8'h10);
    wait_irq();
    m_evt(POS_UPDATE);
    chk(irqb, 8'(m_irq));
    rd(IDX_CONTROL_B);
    chk(rd_data, exp_q.pop_front());
    @(posedge mclk) #1 rtc_subsys_rst = 1'b1;
    @(posedge mclk) #1 rtc_subsys_rst = 1'b0;
    m_flg = 0;
    m_en = 0;
    m_irq = 0;
    chk(irqb, 8'(m_irq));
    rd(IDX_CONTROL_B);
    chk(rd_data, exp_q.pop_front());
    s = $urandom_range(57);
    hr = $urandom_range(23);
    wr(IDX_CONTROL_B, 8'h80);
    wr(IDX_SEC, 8'(s));
    wr(IDX_HOUR, 8'(hr));
    wr(IDX_MIN, 8'($urandom_range(59)));
    wr(IDX_ALM_SEC, 8'(s + 1));
    wr(IDX_ALM_MIN, WILDCARD_BASE | 8'($urandom_range(63)));
    wr(IDX_ALM_HOUR, 8'(hr));
    rd(IDX_FLAGS_C);
    wr(IDX_CONTROL_B, 8'h00);
    repeat (48) @(posedge mclk);
    m_evt(POS_ALARM);
    m_evt(POS_UPDATE);
    rd(IDX_FLAGS_C);
    chk(rd_data, exp_q.pop_front());
    wr(IDX_CONTROL_B, 8'h10);
    wait_irq();
    m_evt(POS_UPDATE);
    m_wr(IDX_CONTROL_B, 8'h80);
    rtc_host_model_inst.decode(1'b0);
    rd(IDX_FLAGS_C);
    repeat (40) @(posedge mclk) #1;
    chk(irqb, 8'(m_irq));
    rtc_host_model_inst.decode(1'b1);
    rd(IDX_FLAGS_C);
    chk(rd_data, exp_q.pop_front());
    complete_run();
  end
endmodule
